// [ctir_consts.svh]
// Constants for the table index and random index register block
`ifndef CTIR_CONSTS_SVH
`define CTIR_CONSTS_SVH
`define CTIR_REGNUM_INDEX 5'h00
`define CTIR_REGNUM_RANDOM 5'h01
`define CTIR_REGNUM_WIRED 5'h06
`define CTIR_SEL_ZERO 3'h0
`define CTIR_ENTRIES 6'h20
`define CTIR_UPPER 5'h1f
`define CTIR_IDX_MSB 4
`define CTIR_PROBE_BIT 31
`define CTIR_LFSR_SEED 8'ha5
`define CTIR_LFSR_TAPS 8'hb8
`endif

// [ctir_lfsr.sv]
// Free running LFSR that vetoes random index decrements
`timescale 1ns/1ps
`include "ctir_consts.svh"
module ctir_lfsr (
    input wire logic clk_i, // Core clock
    input wire logic rst_b_i, // Synchronised reset, active low
    output logic hold_o // High when this cycle's decrement is skipped
);
    logic [7:0] lfsr_reg;
    logic [7:0] lfsr_next;

    // Galois shift; seed is nonzero so the sequence never locks at zero
    always_comb begin
        lfsr_next = {1'b0, lfsr_reg[7:1]};
        if (lfsr_reg[0]) begin
            lfsr_next = lfsr_next ^ `CTIR_LFSR_TAPS;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lfsr_reg <= `CTIR_LFSR_SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    // Skip about one cycle in four
    assign hold_o = lfsr_reg[0] & lfsr_reg[3];
endmodule

// [ctir_pipe_model.sv]
// Pipeline model issuing control register moves and probe results
`timescale 1ns/1ps
module ctir_pipe_model (
    input wire logic clk_i, // Core clock
    input wire logic [31:0] rdata_i, // Read data
    input wire logic rvalid_i, // Read data valid
    output ctir_pkg::ctir_req_t req_o, // Register access
    output ctir_pkg::ctir_probe_t probe_o // Probe outcome
);
    initial begin
        req_o = '0;
        probe_o = '0;
    end
    // Idle regnum and wdata scramble so the block cannot lean on stale values
    task automatic idle();
        req_o.wr <= 1'b0;
        req_o.rd <= 1'b0;
        req_o.regnum <= ~req_o.regnum;
        req_o.wdata <= ~req_o.wdata;
    endtask
    // Write strobe stands one cycle; the next access waits a full edge
    task automatic wr_reg(input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, regnum: n, sel: s, wdata: d};
        @(posedge clk_i);
        idle();
    endtask
    // Read data is taken the cycle after the strobe is accepted
    task automatic rd_reg(input logic [4:0] n, input logic [2:0] s, output logic [31:0] d,
                          output logic v);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, regnum: n, sel: s, wdata: ~req_o.wdata};
        @(posedge clk_i);
        idle();
        #1;
        d = rdata_i;
        v = rvalid_i;
    endtask
    // One probe result pulse; miss flag scrambles when idle
    task automatic probe(input logic m);
        @(posedge clk_i);
        probe_o <= '{probe_done: 1'b1, probe_miss: m};
        @(posedge clk_i);
        probe_o <= '{probe_done: 1'b0, probe_miss: ~m};
    endtask
endmodule

// [ctir_pkg.sv]
// Types for the table index and random index register block
package ctir_pkg;
    // One control register access from the pipeline
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] regnum;
        logic [2:0] sel;
        logic [31:0] wdata;
    } ctir_req_t;
    // Table instruction events
    typedef struct packed {
        logic probe_done;
        logic probe_miss;
    } ctir_probe_t;
endpackage

// [ctir_regs.sv]
// Table index, random index and wired count control registers
`timescale 1ns/1ps
`include "ctir_consts.svh"

// Control register slice of the system control coprocessor: the table
// index, the random replacement index and the wired entry count.
// The pipeline presents one move_to_control_reg or move_from_control_reg
// access per cycle on REQ_I, qualified by register number and select.
// Writes land at the next edge, so a dependent access issued in the very
// next cycle already sees the new value; the pipeline's hazard window is
// therefore zero instructions for this slice.
// Reads return on RDATA_O one cycle after the strobe, flagged by RVALID_O;
// a read and a write in the same cycle return the old contents.
// The random index runs down from the top entry towards the wired count on
// every edge the LFSR does not veto, so table_write_random_instr lands on a
// spread of entries without a true random source.
// A wired write reloads the random index to the top entry; writing the top
// entry number into the wired count freezes the random index there.
// Limitation: the table size is fixed at 32 entries, so the 5-bit fields
// need no width check; software must still keep index and wired below the
// entry count or the table behaviour is undefined.
// The probe flag and index reset to zero although their contents are
// formally undefined, which keeps simulation free of unknowns.

// Functional notes
// - Registers addressed by number 0-31 and select
// - Writes take effect after the access cycle
// - Read/write fields readable, writable, hardware-visible
// - Read-only fields ignore software writes
// - Probe flag updated only by a probe
// - Write-only fields accept writes, reads undefined
// - Zero fields read zero, writes ignored
// - Index reg 0, random 1, wired 6
// - Index field bits 4:0 selects table entry
// - Index width covers all table entries
// - Bit 31 set on probe miss
// - Index bits 30:5 read zero
// - Random read-only, selects random write entry
// - Random lower bound is wired count
// - Random upper bound is entries minus one
// - Random decrements, wraps at wired count
// - LFSR pseudo-randomly skips decrements
// - Random loads upper bound on reset, wired write
// - Random bits 31:5 read zero
module ctir_regs (
    input wire logic CLK_I, // Core clock, 250 MHz
    input wire logic RST_B_I, // Reset exception, active low, async
    input wire ctir_pkg::ctir_req_t REQ_I, // Move to/from control register access
    input wire ctir_pkg::ctir_probe_t PROBE_I, // Probe instruction result
    output logic [31:0] RDATA_O, // Registered read data
    output logic RVALID_O, // Read data valid pulse
    output logic [4:0] INDEX_O, // Entry for probe, read, indexed write
    output logic [4:0] RANDOM_O, // Entry for random write
    output logic [4:0] WIRED_O // Wired entry count
);
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_b;
    logic hold;
    logic probe_reg;
    logic probe_next;
    logic [4:0] index_reg;
    logic [4:0] index_next;
    logic [4:0] random_reg;
    logic [4:0] random_next;
    logic [4:0] wired_reg;
    logic [4:0] wired_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic hit_index;
    logic hit_random;
    logic hit_wired;

    // Reset release synchroniser; assertion stays asynchronous
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_b = rst_s2_reg;

    // Decrement veto source
    ctir_lfsr u_lfsr (
        .clk_i(CLK_I),
        .rst_b_i(rst_b),
        .hold_o(hold)
    );

    // Register selection by number and select; unmapped numbers read zero
    always_comb begin
        hit_index = 1'b0;
        hit_random = 1'b0;
        hit_wired = 1'b0;
        if (REQ_I.sel != `CTIR_SEL_ZERO) begin
            hit_index = 1'b0;
        end else if (REQ_I.regnum == `CTIR_REGNUM_INDEX) begin
            hit_index = 1'b1;
        end else if (REQ_I.regnum == `CTIR_REGNUM_RANDOM) begin
            hit_random = 1'b1;
        end else if (REQ_I.regnum == `CTIR_REGNUM_WIRED) begin
            hit_wired = 1'b1;
        end
    end

    // Index and probe flag next state
    always_comb begin
        index_next = index_reg;
        probe_next = probe_reg;
        if (REQ_I.wr && hit_index) begin
            // Only the 5-bit field stores; bit 31 and 30:5 writes are dropped
            index_next = REQ_I.wdata[`CTIR_IDX_MSB:0];
        end
        if (PROBE_I.probe_done) begin
            probe_next = PROBE_I.probe_miss;
        end
    end

    // Wired count next state; writes at or above entry count are software's fault
    always_comb begin
        wired_next = wired_reg;
        if (REQ_I.wr && hit_wired) begin
            wired_next = REQ_I.wdata[`CTIR_IDX_MSB:0];
        end
    end

    // Random index: counts down from upper bound, wraps at wired count
    always_comb begin
        random_next = random_reg;
        if (REQ_I.wr && hit_wired) begin
            random_next = `CTIR_UPPER;
        end else if (wired_reg == `CTIR_UPPER) begin
            random_next = `CTIR_UPPER;
        end else if (hold) begin
            random_next = random_reg;
        end else if (random_reg <= wired_reg) begin
            random_next = `CTIR_UPPER;
        end else begin
            random_next = random_reg - 5'h01;
        end
    end

    // Read mux; random ignores writes, upper bits read zero except the probe flag in index bit 31
    always_comb begin
        rdata_next = 32'h0000_0000;
        rvalid_next = REQ_I.rd;
        if (REQ_I.rd && hit_index) begin
            rdata_next[`CTIR_PROBE_BIT] = probe_reg;
            rdata_next[`CTIR_IDX_MSB:0] = index_reg;
        end else if (REQ_I.rd && hit_random) begin
            rdata_next[`CTIR_IDX_MSB:0] = random_reg;
        end else if (REQ_I.rd && hit_wired) begin
            rdata_next[`CTIR_IDX_MSB:0] = wired_reg;
        end
    end

    // State registers; new values visible one cycle after the write
    always_ff @(posedge CLK_I or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= 5'h00;
            probe_reg <= 1'b0;
            wired_reg <= 5'h00;
            random_reg <= `CTIR_UPPER;
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            index_reg <= index_next;
            probe_reg <= probe_next;
            wired_reg <= wired_next;
            random_reg <= random_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA_O = rdata_reg;
    assign RVALID_O = rvalid_reg;
    assign INDEX_O = index_reg;
    assign RANDOM_O = random_reg;
    assign WIRED_O = wired_reg;

    // No write-only fields exist here, so nothing returns undefined data

    // Checks on the register state and read path; the assertions watch the registers,
    // decode signals, outputs and LFSR state alongside the REQ_I and PROBE_I inputs from the pipeline.
    // The reset synchroniser output gates them all, so the first edges
    // after release are not judged against pre-reset history.
    // Random index sequencing, probe flag, reserved bit and index write checks
    AST_RANDOM_RANGE: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (wired_reg != `CTIR_UPPER) |-> (random_reg >= wired_reg || $past(REQ_I.wr && hit_wired)))
        else $error("random below wired count");
    AST_WIRED_LOAD: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.wr && hit_wired) |=> (random_reg == `CTIR_UPPER))
        else $error("random not reloaded on wired write");
    AST_WRAP: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (!(REQ_I.wr && hit_wired) && !hold && random_reg == wired_reg)
        |=> (random_reg == `CTIR_UPPER))
        else $error("random did not wrap");
    AST_DEC: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (!(REQ_I.wr && hit_wired) && !hold && random_reg > wired_reg)
        |=> (random_reg == $past(random_reg) - 5'h01))
        else $error("random did not decrement");
    AST_HOLD: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (!(REQ_I.wr && hit_wired) && hold) |=> $stable(random_reg))
        else $error("random moved during veto");
    AST_FROZEN: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (wired_reg == `CTIR_UPPER) |=> (random_reg == `CTIR_UPPER))
        else $error("random moved with full wired count");
    AST_PROBE: assert property (@(posedge CLK_I) disable iff (!rst_b)
        PROBE_I.probe_done |=> (probe_reg == $past(PROBE_I.probe_miss)))
        else $error("probe flag wrong");
    AST_RD_ZERO: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_index) |=> (RDATA_O[30:5] == 26'h0 && RVALID_O))
        else $error("index reserved bits nonzero");
    AST_RANDOM_RO: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_random) |=> (RDATA_O[31:5] == 27'h0))
        else $error("random reserved bits nonzero");
    AST_IDX_WR: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.wr && hit_index) |=> (index_reg == $past(REQ_I.wdata[4:0])))
        else $error("index write lost");

    // Decode checks
    // A nonzero select never reaches any register
    AST_SEL_GATE: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.sel != `CTIR_SEL_ZERO) |-> (!hit_index && !hit_random && !hit_wired))
        else $error("nonzero select decoded");
    // Index sits at register number zero
    AST_MAP_INDEX: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.sel == `CTIR_SEL_ZERO && REQ_I.regnum == `CTIR_REGNUM_INDEX) |-> hit_index)
        else $error("index not decoded");
    // Random index sits at register number one
    AST_MAP_RANDOM: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.sel == `CTIR_SEL_ZERO && REQ_I.regnum == `CTIR_REGNUM_RANDOM) |-> hit_random)
        else $error("random not decoded");
    // Wired count sits at register number six
    AST_MAP_WIRED: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.sel == `CTIR_SEL_ZERO && REQ_I.regnum == `CTIR_REGNUM_WIRED) |-> hit_wired)
        else $error("wired not decoded");
    // At most one register is selected at a time
    AST_ONE_HIT: assert property (@(posedge CLK_I) disable iff (!rst_b)
        $onehot0({hit_index, hit_random, hit_wired}))
        else $error("several registers decoded");

    // Read path checks
    // Every read strobe gets a valid pulse
    AST_RVALID_RISE: assert property (@(posedge CLK_I) disable iff (!rst_b)
        REQ_I.rd |=> RVALID_O)
        else $error("read not answered");
    // No valid pulse without a read
    AST_RVALID_LOW: assert property (@(posedge CLK_I) disable iff (!rst_b)
        !REQ_I.rd |=> !RVALID_O)
        else $error("spurious read valid");
    // Unmapped numbers and selects read as zero
    AST_UNMAPPED_ZERO: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && !hit_index && !hit_random && !hit_wired) |=> (RDATA_O == 32'h0000_0000))
        else $error("unmapped read nonzero");
    // Index field reads back what is stored
    AST_IDX_READBACK: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_index) |=> (RDATA_O[4:0] == $past(index_reg)))
        else $error("index read mismatch");
    // Probe flag appears in the top bit of the index read
    AST_PROBE_READ: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_index) |=> (RDATA_O[31] == $past(probe_reg)))
        else $error("probe flag read mismatch");
    // Random field reads back the live count
    AST_RANDOM_READ: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_random) |=> (RDATA_O[4:0] == $past(random_reg)))
        else $error("random read mismatch");
    // Wired count reads back in full, upper bits zero
    AST_WIRED_READ: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.rd && hit_wired) |=> (RDATA_O == {27'h0, $past(wired_reg)}))
        else $error("wired read mismatch");
    // Read data is cleared between reads
    AST_IDLE_RDATA: assert property (@(posedge CLK_I) disable iff (!rst_b)
        !REQ_I.rd |=> (RDATA_O == 32'h0000_0000))
        else $error("read data left standing");

    // Write path checks
    // Index holds without a write
    AST_IDX_KEEP: assert property (@(posedge CLK_I) disable iff (!rst_b)
        !(REQ_I.wr && hit_index) |=> $stable(index_reg))
        else $error("index moved without write");
    // Probe flag holds without a probe
    AST_PROBE_KEEP: assert property (@(posedge CLK_I) disable iff (!rst_b)
        !PROBE_I.probe_done |=> $stable(probe_reg))
        else $error("probe flag moved without probe");
    // Software writes never touch the probe flag
    AST_PROBE_SW_IGNORED: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.wr && hit_index && !PROBE_I.probe_done) |=> $stable(probe_reg))
        else $error("probe flag written by software");
    // A miss sets the flag
    AST_PROBE_SET: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (PROBE_I.probe_done && PROBE_I.probe_miss) |=> probe_reg)
        else $error("probe miss not flagged");
    // A hit clears the flag
    AST_PROBE_CLR: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (PROBE_I.probe_done && !PROBE_I.probe_miss) |=> !probe_reg)
        else $error("probe hit left flag set");
    // Wired write stores the low field
    AST_WIRED_WR: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.wr && hit_wired) |=> (wired_reg == $past(REQ_I.wdata[4:0])))
        else $error("wired write lost");
    // Wired holds without a write
    AST_WIRED_KEEP: assert property (@(posedge CLK_I) disable iff (!rst_b)
        !(REQ_I.wr && hit_wired) |=> $stable(wired_reg))
        else $error("wired moved without write");

    // Random source checks
    // A write to the random index does not load it
    AST_RANDOM_SW_IGNORED: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (REQ_I.wr && hit_random && !hold && random_reg > wired_reg)
        |=> (random_reg == $past(random_reg) - 5'h01))
        else $error("random index took a write");
    // A veto at the floor keeps the floor value
    AST_FLOOR_HOLD: assert property (@(posedge CLK_I) disable iff (!rst_b)
        (!(REQ_I.wr && hit_wired) && hold && random_reg == wired_reg)
        |=> (random_reg == wired_reg))
        else $error("random left floor during veto");
    // Each step holds, drops by one or returns to the top
    AST_RANDOM_STEP: assert property (@(posedge CLK_I) disable iff (!rst_b)
        1'b1 |=> (random_reg == $past(random_reg) || random_reg == `CTIR_UPPER
        || random_reg == $past(random_reg) - 5'h01))
        else $error("random jumped");
    // The veto source never locks up at zero
    AST_LFSR_ALIVE: assert property (@(posedge CLK_I) disable iff (!rst_b)
        u_lfsr.lfsr_reg != 8'h00)
        else $error("veto source locked at zero");

    COV_WRAP: cover property (@(posedge CLK_I) disable iff (!rst_b)
        random_reg == wired_reg ##1 random_reg == `CTIR_UPPER);
    COV_MISS: cover property (@(posedge CLK_I) disable iff (!rst_b)
        PROBE_I.probe_done && PROBE_I.probe_miss);
    COV_WIRED: cover property (@(posedge CLK_I) disable iff (!rst_b)
        REQ_I.wr && hit_wired);
    COV_HOLD: cover property (@(posedge CLK_I) disable iff (!rst_b)
        hold && wired_reg != `CTIR_UPPER);
    COV_RD_RANDOM: cover property (@(posedge CLK_I) disable iff (!rst_b)
        REQ_I.rd && hit_random);
endmodule

// [tb_ctir_regs.sv]
// Self-checking testbench for the index and random index registers
`timescale 1ns/1ps
`include "ctir_consts.svh"
module tb_ctir_regs;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ctir_pkg::ctir_req_t req;
    ctir_pkg::ctir_probe_t prb;
    logic [31:0] rdata;
    logic rvalid;
    logic [4:0] index;
    logic [4:0] rnd;
    logic [4:0] wired;
    logic [31:0] d;
    logic v;
    int num_errors = 0;
    int checks = 0;
    int h;
    int s;
    int w;
    // Clock, 4 ns period
    always #2 clk = ~clk;
    ctir_regs dut_u (.CLK_I(clk), .RST_B_I(rst_b), .REQ_I(req), .PROBE_I(prb),
        .RDATA_O(rdata), .RVALID_O(rvalid), .INDEX_O(index), .RANDOM_O(rnd), .WIRED_O(wired));
    ctir_pipe_model pipe_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req),
        .probe_o(prb));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Random index may hold, step down by one, or wrap from the floor to the top
    task automatic watch(input int n, input logic [4:0] lo, output int ho, output int st,
                         output int wr);
        logic [4:0] prev;
        ho = 0;
        st = 0;
        wr = 0;
        prev = rnd;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (rnd === prev) ho++;
            else if (prev === lo && rnd === `CTIR_UPPER) wr++;
            else if (prev > lo && rnd === prev - 5'h01) st++;
            else chk({27'h0, rnd}, {27'h0, prev});
            prev = rnd;
        end
    endtask
    // Hang guard, well past the expected run length
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        chk(rnd, 32'h1f);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        pipe_u.rd_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h0);
        chk({31'h0, v}, 32'h1);
        pipe_u.wr_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, 32'h8000_0013);
        pipe_u.rd_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h13);
        chk(index, 32'h13);
        pipe_u.probe(1'b1);
        pipe_u.wr_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, 32'h1f);
        pipe_u.rd_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h8000_001f);
        pipe_u.probe(1'b0);
        pipe_u.rd_reg(`CTIR_REGNUM_INDEX, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h1f);
        pipe_u.wr_reg(`CTIR_REGNUM_WIRED, `CTIR_SEL_ZERO, 32'h4);
        #1;
        chk({wired, rnd}, {5'h04, 5'h1f});
        watch(300, 5'h04, h, s, w);
        chk({h > 0, s > 0, w > 0}, 3'b111);
        pipe_u.rd_reg(`CTIR_REGNUM_RANDOM, `CTIR_SEL_ZERO, d, v);
        chk({d[31:5], d[4:0] >= 5'h04}, 28'h1);
        pipe_u.rd_reg(`CTIR_REGNUM_WIRED, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h4);
        pipe_u.wr_reg(`CTIR_REGNUM_RANDOM, `CTIR_SEL_ZERO, 32'h0);
        pipe_u.rd_reg(`CTIR_REGNUM_RANDOM, `CTIR_SEL_ZERO, d, v);
        chk({d[31:5], d[4:0] >= 5'h04}, 28'h1);
        pipe_u.rd_reg(5'h02, `CTIR_SEL_ZERO, d, v);
        chk(d, 32'h0);
        chk({31'h0, v}, 32'h1);
        pipe_u.rd_reg(`CTIR_REGNUM_INDEX, 3'h1, d, v);
        chk(d, 32'h0);
        pipe_u.wr_reg(`CTIR_REGNUM_WIRED, `CTIR_SEL_ZERO, 32'h1f);
        pipe_u.wr_reg(`CTIR_REGNUM_RANDOM, `CTIR_SEL_ZERO, 32'h0);
        watch(40, 5'h1f, h, s, w);
        chk(h, 40);
        print_verdict();
    end
endmodule
